// file: rtl/kbc_map.svh
// register map, field positions, reset values and timing counts of the keyboard host port
`ifndef KBC_MAP_SVH
`define KBC_MAP_SVH

// ----------------------------------------------------------------
// host and configuration addresses
// ----------------------------------------------------------------
`define KBC_DATA_PORT_ADDR    8'h60
`define KBC_CONTROL_PORT_ADDR 8'h64
`define KBC_SELECT_ADDR       8'hf1

// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define KBC_ST_OBF            0
`define KBC_ST_IBF            1
`define KBC_ST_CMD            3
`define KBC_ST_USER_MASK      8'hf4
`define KBC_STATUS_RESET      8'h00
`define KBC_SEL_SWAP          0
`define KBC_SELECT_RESET      8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define KBC_CLK_MHZ           25
`define KBC_LEGACY_HIGH_NS    500
`define KBC_LEGACY_HIGH_CYC   ((`KBC_LEGACY_HIGH_NS * `KBC_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// memories
// ----------------------------------------------------------------
`define KBC_ROM_BYTES         2048
`define KBC_RAM_BYTES         256

`endif

// file: rtl/kbc_pkg.sv
// types shared by the keyboard host port design
package kbc_pkg;

  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } in_entry_t;

  typedef struct packed {
    logic clockDrive;
    logic dataDrive;
  } ps_drive_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_OSC_OFF
  } power_state_t;

endpackage

// file: rtl/kbd_ctrl_host_interface.sv
// host mailbox, irq gating, pin drive and power control of the keyboard controller
`timescale 1ns/100ps
`include "kbc_map.svh"

// ----------------------------------------------------------------
// input queue
// ----------------------------------------------------------------
module kbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR   = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign inReady  = (count != FULL_COUNT);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= bump(wrPtr);
      end
      if (pop) begin
        rdPtr <= bump(rdPtr);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module kbd_ctrl_host_interface
  import kbc_pkg::*;
#(
  parameter int FIFO_DEPTH  = 16,
  parameter int LEGACY_BITS = 3
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // host port
  input  wire logic                   hostWrite,
  input  wire logic                   hostRead,
  input  wire logic                   hostAddrBit2,
  input  wire logic [7:0]             hostWData,
  output logic                        hostWriteReady,
  output logic [7:0]                  hostRData,
  // configuration port
  input  wire logic                   cfgWrite,
  input  wire logic                   cfgRead,
  input  wire logic [7:0]             cfgAddr,
  input  wire logic [7:0]             cfgWData,
  output logic [7:0]                  cfgRData,
  // controller mailbox
  input  wire logic                   cpuMailboxWrite,
  input  wire logic [7:0]             cpuWData,
  input  wire logic                   cpuMailboxRead,
  output logic [7:0]                  cpuMailboxInput,
  input  wire logic                   cpuStatusWrite,
  output logic [7:0]                  cpuStatus,
  input  wire logic                   cpuObfClear,
  input  wire logic                   enableFlags,
  // controller port bits
  input  wire logic                   kbdIrqPortBit,
  input  wire logic                   mouseIrqPortBit,
  input  wire logic                   a20GatePortBit,
  input  wire logic                   kbdClockDriveBit,
  input  wire logic                   kbdDataDriveBit,
  input  wire logic                   mouseClockDriveBit,
  input  wire logic                   mouseDataDriveBit,
  input  wire logic [LEGACY_BITS-1:0] legacyOutBits,
  // legacy pin configuration
  input  wire logic                   controllerMode,
  input  wire logic [LEGACY_BITS-1:0] legacyOpenDrain,
  input  wire logic [LEGACY_BITS-1:0] gpInputCfg,
  input  wire logic [LEGACY_BITS-1:0] gpInvertCfg,
  // system outputs
  output logic                        keyboardIrqOut,
  output logic                        mouseIrqOut,
  output logic                        addr20GateSignal,
  // legacy pins
  output logic [LEGACY_BITS-1:0]      legacyPinOut,
  output logic [LEGACY_BITS-1:0]      legacyPinOe,
  // keyboard and mouse pins
  input  wire logic                   keyboardClockPinIn,
  output logic                        keyboardClockPinOut,
  output logic                        keyboardClockPinOe,
  input  wire logic                   keyboardDataPinIn,
  output logic                        keyboardDataPinOut,
  output logic                        keyboardDataPinOe,
  input  wire logic                   mouseClockPinIn,
  output logic                        mouseClockPinOut,
  output logic                        mouseClockPinOe,
  input  wire logic                   mouseDataPinIn,
  output logic                        mouseDataPinOut,
  output logic                        mouseDataPinOe,
  // pin senses to the controller
  output logic                        kbdClockSense,
  output logic                        kbdDataSense,
  output logic                        mouseClockSense,
  output logic                        mouseDataSense,
  // controller interrupts and power
  input  wire logic                   ibfIrqEnable,
  input  wire logic                   timerIrqEnable,
  input  wire logic                   timerOverflow,
  output logic                        cpuIrqIbf,
  output logic                        cpuIrqTimer,
  input  wire logic                   idleRequest,
  input  wire logic                   oscOffRequest,
  output logic                        aluClockEnable,
  output logic                        oscEnable,
  output logic                        wakeCall,
  output logic                        wakeContinue,
  // data memory
  input  wire logic                   ramWrite,
  input  wire logic [7:0]             ramAddr,
  input  wire logic [7:0]             ramWData,
  output logic [7:0]                  ramRData
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  localparam int HOLD_W = 4;
  localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(`KBC_LEGACY_HIGH_CYC);

  // ----------------------------------------------------------------
  // mailbox flags
  // ----------------------------------------------------------------
  in_entry_t  headEntry;
  in_entry_t  newEntry;
  logic       in_buffer_full;
  logic       out_buffer_full;
  logic [7:0] outBuf;
  logic [7:0] userBits;
  logic       swapPins;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifoCount;

  wire hostWriteTaken = hostWrite && hostWriteReady;
  wire dataRead       = hostRead && !hostAddrBit2;
  wire obfHwClear     = (dataRead && enableFlags) || cpuObfClear;
  wire next_obf       = cpuMailboxWrite || (out_buffer_full && !obfHwClear);
  wire cmdFlag        = in_buffer_full && headEntry.cmd;

  assign newEntry = '{cmd: hostAddrBit2, data: hostWData};

  // host byte and its command mark travel together; queue head is the input register
  kbc_fifo #(
    .WIDTH ($bits(in_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (hostWrite),
    .inReady  (hostWriteReady),
    .inData   (newEntry),
    .outValid (in_buffer_full),
    .outReady (cpuMailboxRead),
    .outData  (headEntry),
    .count    (fifoCount)
  );

  assign cpuMailboxInput = headEntry.data;
  assign cpuStatus = (userBits & `KBC_ST_USER_MASK)
                   | (8'(cmdFlag) << `KBC_ST_CMD)
                   | (8'(in_buffer_full) << `KBC_ST_IBF)
                   | (8'(out_buffer_full) << `KBC_ST_OBF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_buffer_full      <= 1'b0;
      outBuf   <= 8'h00;
      userBits <= `KBC_STATUS_RESET;
    end else begin
      out_buffer_full <= next_obf;
      if (cpuMailboxWrite) begin
        outBuf <= cpuWData;
      end
      if (cpuStatusWrite) begin
        userBits <= cpuWData & `KBC_ST_USER_MASK;
      end
    end
  end

  a_obf_set:   assert property (cpuMailboxWrite |=> out_buffer_full)
    else $error("output full not set by controller write");
  a_obf_clear: assert property (dataRead && enableFlags && !cpuMailboxWrite |=> !out_buffer_full)
    else $error("output full not cleared by host data read");
  a_data_cd:   assert property (hostWriteTaken && !hostAddrBit2 && fifoCount == '0
                                |=> in_buffer_full && !cpuStatus[`KBC_ST_CMD])
    else $error("data write did not set input full with data mark");
  a_cmd_cd:    assert property (hostWriteTaken && hostAddrBit2 && fifoCount == '0
                                |=> in_buffer_full && cpuStatus[`KBC_ST_CMD])
    else $error("command write did not set input full with command mark");
  a_ibf_clear: assert property (cpuMailboxRead && fifoCount == 1 && !hostWriteTaken
                                |=> !in_buffer_full)
    else $error("input full not cleared by controller read");

  // ----------------------------------------------------------------
  // host and configuration reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hostRData <= 8'h00;
      cfgRData  <= 8'h00;
      swapPins  <= 1'b0;
    end else begin
      if (hostRead) begin
        hostRData <= hostAddrBit2 ? cpuStatus : outBuf;
      end
      if (cfgWrite && cfgAddr == `KBC_SELECT_ADDR) begin
        swapPins <= cfgWData[`KBC_SEL_SWAP];
      end
      if (cfgRead) begin
        cfgRData <= (cfgAddr == `KBC_SELECT_ADDR) ? 8'(swapPins) << `KBC_SEL_SWAP : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // system irqs and gate
  // ----------------------------------------------------------------
  wire next_kbdIrq   = enableFlags ? (kbdIrqPortBit && next_obf) : kbdIrqPortBit;
  wire next_mouseIrq = enableFlags ? (mouseIrqPortBit && !in_buffer_full) : mouseIrqPortBit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keyboardIrqOut   <= 1'b0;
      mouseIrqOut      <= 1'b0;
      addr20GateSignal <= 1'b0;
    end else begin
      keyboardIrqOut   <= next_kbdIrq;
      mouseIrqOut      <= next_mouseIrq;
      addr20GateSignal <= a20GatePortBit;
    end
  end

  a_keyboard_irq_out_forced: assert property (enableFlags && !kbdIrqPortBit |=> !keyboardIrqOut)
    else $error("keyboard irq not forced low");
  a_keyboard_irq_out_follow: assert property (enableFlags && kbdIrqPortBit |=> keyboardIrqOut == out_buffer_full)
    else $error("keyboard irq does not follow output full");
  a_keyboard_irq_out_direct: assert property (!enableFlags |=> keyboardIrqOut == $past(kbdIrqPortBit))
    else $error("keyboard irq does not follow port bit");
  a_mouse_irq_out_gate:   assert property (enableFlags && mouseIrqPortBit
                                  |=> mouseIrqOut == !$past(in_buffer_full))
    else $error("mouse irq does not carry inverted input full");
  a_mouse_irq_out_direct: assert property (!enableFlags |=> mouseIrqOut == $past(mouseIrqPortBit))
    else $error("mouse irq does not follow port bit");

  // ----------------------------------------------------------------
  // legacy port pins
  // ----------------------------------------------------------------
  logic [LEGACY_BITS-1:0] prevBits;
  logic [HOLD_W-1:0]      holdCnt [LEGACY_BITS];
  logic [LEGACY_BITS-1:0] effBits;
  logic [LEGACY_BITS-1:0] effInput;

  // outside controller mode the general-purpose settings apply
  assign effBits  = controllerMode ? legacyOutBits : (legacyOutBits ^ gpInvertCfg);
  assign effInput = controllerMode ? '0 : gpInputCfg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevBits     <= '0;
      legacyPinOut <= '0;
      legacyPinOe  <= '0;
      for (int i = 0; i < LEGACY_BITS; i++) begin
        holdCnt[i] <= '0;
      end
    end else begin
      prevBits <= effBits;
      for (int i = 0; i < LEGACY_BITS; i++) begin
        // a rising bit that is not open-drain drives high for a short while before the pull-up takes over
        if (effBits[i] && !prevBits[i] && !legacyOpenDrain[i]) begin
          holdCnt[i] <= HOLD_CYC;
        end else if (!effBits[i] || legacyOpenDrain[i]) begin
          holdCnt[i] <= '0;
        end else if (holdCnt[i] != '0) begin
          holdCnt[i] <= holdCnt[i] - 1'b1;
        end
        legacyPinOut[i] <= effBits[i];
        legacyPinOe[i]  <= !effInput[i] && (!effBits[i] ||
                           (!legacyOpenDrain[i] && (holdCnt[i] != '0 || !prevBits[i])));
      end
    end
  end

  a_legacy_low:  assert property (controllerMode && !legacyOutBits[0]
                                  |=> legacyPinOe[0] && !legacyPinOut[0])
    else $error("legacy pin zero not driven low");
  a_legacy_od:   assert property (controllerMode && legacyOpenDrain[0] && legacyOutBits[0]
                                  |=> !legacyPinOe[0])
    else $error("open-drain legacy pin driven high");
  a_legacy_hold: assert property (controllerMode && !legacyOpenDrain[0] && $rose(legacyOutBits[0])
                                  ##1 (controllerMode && !legacyOpenDrain[0] && legacyOutBits[0])[*8]
                                  |-> legacyPinOe[0])
    else $error("legacy pin released too early");

  // ----------------------------------------------------------------
  // keyboard and mouse pins
  // ----------------------------------------------------------------
  ps_drive_t kbdSide;
  ps_drive_t mouseSide;
  logic [3:0] pinSync1;
  logic [3:0] pinSync2;

  // a drive bit of one pulls its open-drain pin low
  assign kbdSide   = swapPins ? '{mouseClockDriveBit, mouseDataDriveBit}
                              : '{kbdClockDriveBit, kbdDataDriveBit};
  assign mouseSide = swapPins ? '{kbdClockDriveBit, kbdDataDriveBit}
                              : '{mouseClockDriveBit, mouseDataDriveBit};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keyboardClockPinOe <= 1'b0;
      keyboardDataPinOe  <= 1'b0;
      mouseClockPinOe    <= 1'b0;
      mouseDataPinOe     <= 1'b0;
      pinSync1           <= '0;
      pinSync2           <= '0;
    end else begin
      keyboardClockPinOe <= kbdSide.clockDrive;
      keyboardDataPinOe  <= kbdSide.dataDrive;
      mouseClockPinOe    <= mouseSide.clockDrive;
      mouseDataPinOe     <= mouseSide.dataDrive;
      pinSync1 <= {mouseDataPinIn, mouseClockPinIn, keyboardDataPinIn, keyboardClockPinIn};
      pinSync2 <= pinSync1;
    end
  end

  assign keyboardClockPinOut = 1'b0;
  assign keyboardDataPinOut  = 1'b0;
  assign mouseClockPinOut    = 1'b0;
  assign mouseDataPinOut     = 1'b0;
  assign kbdClockSense   = swapPins ? pinSync2[2] : pinSync2[0];
  assign kbdDataSense    = swapPins ? pinSync2[3] : pinSync2[1];
  assign mouseClockSense = swapPins ? pinSync2[0] : pinSync2[2];
  assign mouseDataSense  = swapPins ? pinSync2[1] : pinSync2[3];

  a_pin_swap: assert property (##1 keyboardClockPinOe == $past(swapPins ? mouseClockDriveBit
                                                            : kbdClockDriveBit))
    else $error("keyboard clock pin drive wrong for swap setting");

  // ----------------------------------------------------------------
  // controller interrupts and power-down
  // ----------------------------------------------------------------
  power_state_t pwrState;

  assign cpuIrqIbf      = in_buffer_full && ibfIrqEnable;
  assign cpuIrqTimer    = timerOverflow && timerIrqEnable;
  assign aluClockEnable = (pwrState == PWR_RUN);
  assign oscEnable      = (pwrState != PWR_OSC_OFF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwrState     <= PWR_RUN;
      wakeCall     <= 1'b0;
      wakeContinue <= 1'b0;
    end else begin
      wakeCall     <= 1'b0;
      wakeContinue <= 1'b0;
      unique case (pwrState)
        PWR_RUN: begin
          if (oscOffRequest) begin
            pwrState <= PWR_OSC_OFF;
          end else if (idleRequest) begin
            pwrState <= PWR_IDLE;
          end
        end
        PWR_IDLE, PWR_OSC_OFF: begin
          if (hostWriteTaken) begin
            pwrState     <= PWR_RUN;
            wakeCall     <= ibfIrqEnable;
            wakeContinue <= !ibfIrqEnable;
          end
        end
      endcase
    end
  end

  a_host_wake: assert property (pwrState != PWR_RUN && hostWriteTaken
                                |=> aluClockEnable && oscEnable && (wakeCall != wakeContinue))
    else $error("host write did not wake the controller");

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  logic [7:0] dataRam [`KBC_RAM_BYTES];

  always_ff @(posedge clk_sys) begin
    if (ramWrite) begin
      dataRam[ramAddr] <= ramWData;
    end
    ramRData <= dataRam[ramAddr];
  end
endmodule

// file: dv/kbc_host_master.sv
// host bus master model issuing single-byte port reads and writes
`timescale 1ns/100ps
module kbc_host_master (
  // clock
  input  wire logic       clk_sys,
  // host port
  output logic            hostWrite,
  output logic            hostRead,
  output logic            hostAddrBit2,
  output logic [7:0]      hostWData,
  input  wire logic       hostWriteReady,
  input  wire logic [7:0] hostRData
);
  initial begin
    hostWrite = 1'h0;
    hostRead = 1'h0;
    hostAddrBit2 = 1'h0;
    hostWData = 8'h00;
  end
  // write held until ready is seen, given up after 8 cycles
  task automatic wr(input logic a, input logic [7:0] d, output bit ok);
    ok = 1'h0;
    hostAddrBit2 = a;
    hostWData = d;
    hostWrite = 1'h1;
    for (int i = 0; i < 8 && !ok; i++) begin
      ok = hostWriteReady;
      @(negedge clk_sys);
    end
    hostWrite = 1'h0;
    hostWData = ~d;
  endtask
  task automatic rd(input logic a, output logic [7:0] d);
    hostAddrBit2 = a;
    hostRead = 1'h1;
    @(negedge clk_sys);
    hostRead = 1'h0;
    d = hostRData;
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the keyboard controller host port
`timescale 1ns/100ps
`include "kbc_map.svh"
module tb
  import kbc_pkg::*;
;
  logic clk_sys = 1'h0, rst = 1'h1, hostWrite, hostRead, hostAddrBit2, hostWriteReady;
  logic [7:0] hostWData, hostRData, cfgRData, cpuMailboxInput, cpuStatus, ramRData;
  logic cfgWrite = 1'h0, cfgRead = 1'h0, cpuMailboxWrite = 1'h0, cpuMailboxRead = 1'h0;
  logic [7:0] cfgAddr = 8'h00, cfgWData = 8'h00, cpuWData = 8'h00, ramAddr = 8'h00;
  logic [7:0] ramWData = 8'h00;
  logic cpuStatusWrite = 1'h0, cpuObfClear = 1'h0, enableFlags = 1'h0, kbdIrqPortBit = 1'h0;
  logic mouseIrqPortBit = 1'h0, a20GatePortBit = 1'h0, kbdClockDriveBit = 1'h0;
  logic kbdDataDriveBit = 1'h0, mouseClockDriveBit = 1'h0, mouseDataDriveBit = 1'h0;
  logic [2:0] legacyOutBits = 3'h0, legacyOpenDrain = 3'h2, gpInputCfg = 3'h7, gpInvertCfg = 3'h7;
  logic controllerMode = 1'h1, ibfIrqEnable = 1'h0, timerIrqEnable = 1'h0, timerOverflow = 1'h0;
  logic idleRequest = 1'h0, oscOffRequest = 1'h0, ramWrite = 1'h0;
  logic keyboardIrqOut, mouseIrqOut, addr20GateSignal, cpuIrqIbf, cpuIrqTimer;
  logic keyboardClockPinOut, keyboardClockPinOe, keyboardDataPinOut, keyboardDataPinOe;
  logic mouseClockPinOut, mouseClockPinOe, mouseDataPinOut, mouseDataPinOe;
  logic kbdClockSense, kbdDataSense, mouseClockSense, mouseDataSense;
  logic aluClockEnable, oscEnable, wakeCall, wakeContinue;
  logic [2:0] legacyPinOut, legacyPinOe;
  // open-drain pins with pull-ups: high unless someone drives low
  wire logic keyboardClockPinIn = !keyboardClockPinOe;
  wire logic keyboardDataPinIn  = !keyboardDataPinOe;
  wire logic mouseClockPinIn    = !mouseClockPinOe;
  wire logic mouseDataPinIn     = !mouseDataPinOe;
  logic [8:0] q[$];
  logic [8:0] e;
  logic [7:0] r = 8'h17, d;
  bit ok, k;
  int mismatches = 0, checks = 0;
  kbd_ctrl_host_interface i_dut (.*);
  kbc_host_master i_host (.*);
  initial forever #20 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic ck(input logic [7:0] a, input logic [7:0] x);
    checks++;
    if (a !== x) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, a, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] v);
    cfgWrite = w;
    cfgRead = !w;
    cfgAddr = a;
    cfgWData = v;
    cyc(1);
    cfgWrite = 1'h0;
    cfgRead = 1'h0;
    if (!w) ck(cfgRData, v);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task results;
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    rst = 1'h0;
    ck(cpuStatus, `KBC_STATUS_RESET);
    ck(keyboardIrqOut, 8'h00);
    cfg(1'h0, `KBC_SELECT_ADDR, 8'h00);
    for (int i = 0; i < 17; i++) begin
      r = lf(r);
      i_host.wr(r[2], r, ok);
      if (ok) q.push_back({r[2], r});
      cyc(1);
    end
    ck(q.size(), 8'h10);
    ck(hostWriteReady, 8'h00);
    while (q.size() > 0) begin
      e = q.pop_front();
      ck(cpuMailboxInput, e[7:0]);
      ck(cpuStatus[3:1], {e[8], 2'h1});
      pulse(cpuMailboxRead);
      cyc(1);
    end
    ck(cpuStatus[1], 8'h00);
    {enableFlags, kbdIrqPortBit, mouseIrqPortBit} = 3'h7;
    cpuWData = lf(r);
    pulse(cpuMailboxWrite);
    ck({cpuStatus[0], keyboardIrqOut, mouseIrqOut}, 8'h07);
    i_host.rd(1'h0, d);
    ck(d, lf(r));
    ck({cpuStatus[0], keyboardIrqOut}, 8'h00);
    i_host.wr(1'h0, r, ok);
    cyc(1);
    ck(mouseIrqOut, 8'h00);
    kbdIrqPortBit = 1'h0;
    pulse(cpuMailboxWrite);
    ck(keyboardIrqOut, 8'h00);
    enableFlags = 1'h0;
    for (int j = 0; j < 4; j++) begin
      {kbdIrqPortBit, mouseIrqPortBit, a20GatePortBit} = {j[1:0], j[0]};
      cyc(2);
      ck({keyboardIrqOut, mouseIrqOut, addr20GateSignal}, {j[1:0], j[0]});
    end
    {kbdClockDriveBit, kbdDataDriveBit, mouseClockDriveBit, mouseDataDriveBit} = 4'h8;
    cyc(4);
    ck({keyboardClockPinOe, keyboardDataPinOe, mouseClockPinOe, mouseDataPinOe}, 8'h08);
    ck({kbdClockSense, kbdDataSense, mouseClockSense, mouseDataSense}, 8'h07);
    cfg(1'h1, `KBC_SELECT_ADDR, 8'h01);
    cyc(4);
    ck({keyboardClockPinOe, keyboardDataPinOe, mouseClockPinOe, mouseDataPinOe}, 8'h02);
    ck({kbdClockSense, kbdDataSense, mouseClockSense, mouseDataSense}, 8'h07);
    cfg(1'h0, `KBC_SELECT_ADDR, 8'h01);
    cyc(1);
    cfg(1'h0, 8'h20, 8'h00);
    ck({legacyPinOe, legacyPinOut}, 8'h38);
    legacyOutBits = 3'h7;
    cyc(2);
    ck({legacyPinOe, legacyPinOut & legacyPinOe}, 8'h2d);
    cyc(`KBC_LEGACY_HIGH_CYC + 2);
    ck(legacyPinOe, 8'h00);
    controllerMode = 1'h0;
    cyc(2);
    ck(legacyPinOe, 8'h00);
    gpInputCfg = 3'h0;
    cyc(2);
    ck({legacyPinOe, legacyPinOut}, 8'h38);
    {controllerMode, gpInputCfg} = 4'hf;
    pulse(idleRequest);
    ck(aluClockEnable, 8'h00);
    ibfIrqEnable = 1'h1;
    i_host.wr(1'h1, lf(r), ok);
    k = 1'h0;
    repeat (3) begin
      k |= wakeCall;
      cyc(1);
    end
    ck({k, aluClockEnable, cpuIrqIbf}, 8'h07);
    {timerIrqEnable, timerOverflow} = 2'h3;
    cyc(1);
    ck(cpuIrqTimer, 8'h01);
    {ramAddr, ramWData} = {r, ~r};
    pulse(ramWrite);
    cyc(1);
    ck(ramRData, ~r);
    cpuWData = 8'hff;
    pulse(cpuStatusWrite);
    ck(cpuStatus & `KBC_ST_USER_MASK, `KBC_ST_USER_MASK);
    pulse(oscOffRequest);
    ck({oscEnable, aluClockEnable}, 8'h00);
    results();
  end
endmodule
